/* dmd_pkg.sv */
// Purpose: Shared constants and types for the dual-modulus divider control
// Assumes: Counters clocked by the prescaler output sampled on i_ref_clk
// Notes:   Widths are defaults; the top module may override them
package dmd_pkg;

    localparam int DMD_N_WIDTH   = 10;
    localparam int DMD_A_WIDTH   = 7;
    localparam int DMD_P_MIN     = 3;
    localparam int DMD_P_MAX     = 128;
    localparam logic DMD_MOD_LOW  = 1'b0;
    localparam logic DMD_MOD_HIGH = 1'b1;

    typedef enum logic [1:0] {
        DMD_ST_IDLE,
        DMD_ST_SWALLOW,
        DMD_ST_MAIN
    } dmd_state_type;

    typedef struct packed {
        logic [DMD_N_WIDTH-1:0] main_count;
        logic [DMD_A_WIDTH-1:0] swallow_count;
    } dmd_prog_type;

    typedef struct packed {
        logic modulus_select_out;
        logic cycle_done;
    } dmd_stat_type;

endpackage : dmd_pkg

/* dmd_edge_det.sv */
// Purpose: Rising edge detector for the prescaler output
// Assumes: Input synchronous to i_ref_clk
// Notes:   One-cycle pulse per low-to-high transition
`timescale 1ns/1ns
module dmd_edge_det
    import dmd_pkg::*;
(
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_level,
    output logic      o_rise
);
    logic level_r;
    logic rise_r;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            level_r <= i_level;
            rise_r  <= 1'b0;
        end else begin
            level_r <= i_level;
            rise_r  <= i_level & ~level_r;
        end
    end

    assign o_rise = rise_r;
endmodule // dmd_edge_det

/* dmd_divider.sv */
// Purpose: Main and swallow counters steering a dual-modulus prescaler
// Assumes: Program words stable; prescaler output synchronous to i_ref_clk
// Notes:   Total ratio in prescaler input cycles is main*P + swallow
//
// Operation
// - Total ratio equals main times P plus swallow
// - Swallow counts down A..1 while main also counts down, then main counts down alone
// - Modulus select held for required prescaler cycles
// - Works for prescaler ratios 3/4 to 128/129
`timescale 1ns/1ns
module dmd_divider
    import dmd_pkg::*;
#(
    parameter int N_WIDTH = DMD_N_WIDTH,
    parameter int A_WIDTH = DMD_A_WIDTH
) (
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst,
    input  wire logic               i_prescaler_out,
    input  wire logic [N_WIDTH-1:0] i_main_count,
    input  wire logic [A_WIDTH-1:0] i_swallow_count,
    output logic                    o_modulus_select_out,
    output logic                    o_cycle_done
);

    // Phase register and counters
    dmd_state_type          state_r;
    dmd_state_type          state_nxt;
    logic [N_WIDTH-1:0]     main_r;
    logic [N_WIDTH-1:0]     main_nxt;
    logic [A_WIDTH-1:0]     swallow_r;
    logic [A_WIDTH-1:0]     swallow_nxt;
    dmd_stat_type           stat_r;
    dmd_stat_type           stat_nxt;
    logic                   tick;

    // Decoded conditions
    logic                   in_swallow;
    logic                   in_main;
    logic                   main_last;
    logic                   swallow_last;
    logic [N_WIDTH-1:0]     main_dec;
    logic [A_WIDTH-1:0]     swallow_dec;
    logic                   load_modulus;
    dmd_state_type          load_phase;
    logic                   swallow_tick;
    logic                   main_tick;
    logic                   swallow_end;
    logic                   main_end;
    logic                   cycle_end;

    // Counters advance once per prescaler output rising edge
    dmd_edge_det u_edge (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_level   (i_prescaler_out),
        .o_rise    (tick)
    );

    // Modulus that opens a divide cycle
    function automatic logic first_modulus(input logic [A_WIDTH-1:0] swallow);
        if (swallow != '0) begin
            return DMD_MOD_LOW;
        end else begin
            return DMD_MOD_HIGH;
        end
    endfunction

    // Phase that opens a divide cycle
    function automatic dmd_state_type first_phase(input logic [A_WIDTH-1:0] swallow);
        if (swallow != '0) begin
            return DMD_ST_SWALLOW;
        end else begin
            return DMD_ST_MAIN;
        end
    endfunction

    // Main counter on its final group; zero counts as one group
    function automatic logic main_at_end(input logic [N_WIDTH-1:0] count);
        if ((count == N_WIDTH'(1)) || (count == '0)) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // Swallow counter on its final group
    function automatic logic swallow_at_end(input logic [A_WIDTH-1:0] count);
        if (count == A_WIDTH'(1)) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction

    // Each tick is one prescaler group of P or P+1 input cycles.
    // Swallow phase: A groups at P+1; main phase: N-A groups at P.
    // Total = A*(P+1) + (N-A)*P = N*P + A for any P, 3..128.
    assign in_swallow   = (state_r == DMD_ST_SWALLOW);
    assign in_main      = (state_r == DMD_ST_MAIN);
    assign main_last    = main_at_end(main_r);
    assign swallow_last = swallow_at_end(swallow_r);
    assign main_dec     = main_r - N_WIDTH'(1);
    assign swallow_dec  = swallow_r - A_WIDTH'(1);
    assign load_modulus = first_modulus(i_swallow_count);
    assign load_phase   = first_phase(i_swallow_count);
    assign swallow_tick = tick && in_swallow;
    assign main_tick    = tick && in_main;
    assign swallow_end  = swallow_tick && swallow_last;
    assign main_end     = main_tick && main_last;
    assign cycle_end    = (swallow_end && main_last) || main_end;

    // Phase sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DMD_ST_IDLE: begin
                state_nxt = load_phase;
            end
            DMD_ST_SWALLOW: begin
                if (swallow_end) begin
                    state_nxt = main_last ? DMD_ST_IDLE : DMD_ST_MAIN;
                end
            end
            DMD_ST_MAIN: begin
                if (main_end) begin
                    state_nxt = DMD_ST_IDLE;
                end
            end
            default: begin
                state_nxt = DMD_ST_IDLE;
            end
        endcase
    end

    // Counter loading and stepping
    always_comb begin
        main_nxt    = main_r;
        swallow_nxt = swallow_r;
        case (state_r)
            DMD_ST_IDLE: begin
                main_nxt    = i_main_count;
                swallow_nxt = i_swallow_count;
            end
            DMD_ST_SWALLOW: begin
                if (tick) begin
                    main_nxt    = main_dec;
                    swallow_nxt = swallow_dec;
                end
            end
            DMD_ST_MAIN: begin
                if (tick) begin
                    main_nxt = main_dec;
                end
            end
            default: begin
                main_nxt    = '0;
                swallow_nxt = '0;
            end
        endcase
    end

    // Modulus select and end of cycle
    always_comb begin
        stat_nxt            = stat_r;
        stat_nxt.cycle_done = cycle_end;
        case (state_r)
            DMD_ST_IDLE: begin
                stat_nxt.modulus_select_out = load_modulus;
            end
            DMD_ST_SWALLOW: begin
                if (swallow_end) begin
                    stat_nxt.modulus_select_out = DMD_MOD_HIGH;
                end
            end
            DMD_ST_MAIN: begin
                stat_nxt.modulus_select_out = DMD_MOD_HIGH;
            end
            default: begin
                stat_nxt.modulus_select_out = DMD_MOD_HIGH;
            end
        endcase
    end

    // Phase register
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= DMD_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Counters
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            main_r    <= '0;
            swallow_r <= '0;
        end else begin
            main_r    <= main_nxt;
            swallow_r <= swallow_nxt;
        end
    end

    // Registered status
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            stat_r.modulus_select_out <= DMD_MOD_HIGH;
            stat_r.cycle_done         <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // Outputs straight from the status flops
    assign o_modulus_select_out = stat_r.modulus_select_out;
    assign o_cycle_done         = stat_r.cycle_done;
endmodule // dmd_divider

/* dmd_asserts.sv */
// Purpose: Port checks for dmd_divider
// Assumes: Prescaler groups of six clocks or more
// Notes:   Bound at the foot
`timescale 1ns/1ns
module dmd_asserts #(
    parameter int N_WIDTH = 10,
    parameter int A_WIDTH = 7
) (
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst,
    input  wire logic               i_prescaler_out,
    input  wire logic [N_WIDTH-1:0] i_main_count,
    input  wire logic [A_WIDTH-1:0] i_swallow_count,
    input  wire logic               o_modulus_select_out,
    input  wire logic               o_cycle_done
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire m = o_modulus_select_out, d = o_cycle_done, p = i_prescaler_out;
    wire z = i_swallow_count == 0;
    rst_out_a: assert property (disable iff (1'b0) i_rst |=> m && !d) else $error("reset");
    done_one_a: assert property (d |=> !d [*4]) else $error("done width");
    done_src_a: assert property (d |-> $past(p, 2) && !$past(p, 3)) else $error("done cause");
    reload_a: assert property (d && !z |-> ##[1:2] !m) else $error("no reload");
    all_p_a: assert property (d && z |-> ##3 m) else $error("not all P");
    rise_src_a: assert property ($rose(m) |-> $past(p, 2) && !$past(p, 3))
        else $error("rise cause");
    fall_src_a: assert property ($fell(m) |-> $past(d) || $past(d, 2) || $past(i_rst, 2))
        else $error("fall cause");
    low_hold_a: assert property ($fell(m) && !$past(i_rst, 2) |=> !m [*3])
        else $error("low hold");
endmodule // dmd_asserts
bind dmd_divider dmd_asserts #(.N_WIDTH(N_WIDTH), .A_WIDTH(A_WIDTH)) dmd_asserts_i (
    .i_ref_clk            (i_ref_clk),
    .i_rst                (i_rst),
    .i_prescaler_out      (i_prescaler_out),
    .i_main_count         (i_main_count),
    .i_swallow_count      (i_swallow_count),
    .o_modulus_select_out (o_modulus_select_out),
    .o_cycle_done         (o_cycle_done)
);

/* dmd_prescaler.sv */
// Purpose: Prescaler model
// Assumes: One input cycle is two clocks
// Notes:   Output high three clocks a group
`timescale 1ns/1ns
module dmd_prescaler (
    input  wire logic       i_ref_clk,
    input  wire logic       i_mod,
    input  wire logic [7:0] i_p,
    output logic            o_out
);
    int cnt = 0;
    assign o_out = cnt < 3;
    always @(posedge i_ref_clk)
        cnt <= cnt + 1 < 2 * (i_p + !(i_mod === 1'b1)) ? cnt + 1 : 0;
endmodule // dmd_prescaler

/* dual_modulus_divider_control_bench.sv */
// Purpose: Bench for dmd_divider
// Assumes: Prescaler model on the far side
// Notes:   Cycle is twice the total ratio in clocks
`timescale 1ns/1ns
module dual_modulus_divider_control_bench;
    logic clk = 0, rst = 1, pout, mod, done;
    logic [9:0] mc = 10'h002;
    logic [6:0] sc = 7'h01;
    logic [7:0] p = 8'h03;
    int n_errors = 0, checks = 0, last = 0, lows = 0, nt, q[$], ps[3] = '{4, 16, 64};
    dmd_divider dmd_divider_i (.i_ref_clk(clk), .i_rst(rst), .i_prescaler_out(pout),
        .i_main_count(mc), .i_swallow_count(sc), .o_modulus_select_out(mod), .o_cycle_done(done));
    dmd_prescaler dmd_prescaler_i (.i_ref_clk(clk), .i_mod(mod), .i_p(p), .o_out(pout));
    initial forever #5 clk = ~clk;
    initial begin
        #1000000;
        n_errors++;
        complete_run;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %h %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        if (n_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task run(input int np, input int n, input int a);
        @(posedge clk) #1;
        p = np[7:0];
        mc = n[9:0];
        sc = a[6:0];
        repeat (3) @(posedge done);
        repeat (3) begin
            q.push_back(2 * (n * np + a));
            q.push_back(a > 0 ? 2 * a * (np + 1) - 1 : 0);
        end
        wait (q.size() == 0);
    endtask
    always @(posedge clk) begin
        if (done) begin
            if (q.size() > 1) begin
                check(($time - last) / 10, q.pop_front());
                check(lows, q.pop_front());
            end
            last = $time;
            lows = 0;
        end else if (mod === 1'b0) begin
            lows++;
        end
    end
    initial begin
        void'($urandom(32'h0f07_101c));
        repeat (8) @(posedge clk);
        #1 rst = 0;
        run(3, 2, 2);
        run(3, 2, 0);
        run(3, 5, 1);
        nt = 56 + $urandom % 200;
        run(8, nt >> 3, nt & 7);
        foreach (ps[i]) run(ps[i], ps[i] - 1 + $urandom % 4, $urandom % ps[i]);
        @(posedge clk) #1 rst = 1;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        run(4, 3, 3);
        complete_run;
    end
endmodule // dual_modulus_divider_control_bench
